// [core/tlip_pkg.sv]
// Package for the two-level interrupt priority block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package tlip_pkg;

  localparam int          AXI_AW          = 4;
  localparam logic [3:0]  OFS_CTRL0       = 4'h0;
  localparam logic [3:0]  OFS_PRIO7       = 4'h4;
  localparam logic [3:0]  OFS_PRIO8       = 4'h8;
  localparam logic [3:0]  OFS_STATE       = 4'hC;

  localparam int          CTL_GHE_BIT     = 7;
  localparam int          CTL_GLE_BIT     = 6;
  localparam int          CTL_PLE_BIT     = 5;
  localparam logic [7:0]  CTL_WMASK       = 8'hE7;
  localparam logic [7:0]  CTL_RESET       = 8'h07;
  localparam logic [7:0]  PRIO7_WMASK     = 8'h3B;
  localparam logic [7:0]  PRIO7_RESET     = 8'h3B;
  localparam logic [7:0]  PRIO8_WMASK     = 8'hC0;
  localparam logic [7:0]  PRIO8_RESET     = 8'hC0;

  localparam int          NUM_SRC         = 7;
  localparam logic [6:0]  PRIO_RESET_ALL  = 7'h7F;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HIGH,
    ST_LOW,
    ST_LOW_PREEMPTED
  } tlip_svc_type;

endpackage : tlip_pkg

// [core/tlip_edge_det.sv]
// Edge detector for the external interrupt pins with selectable polarity.
// Assumes pins are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module tlip_edge_det #(
  parameter int N = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [N-1:0] i_pin,
  input  wire logic [N-1:0] i_rise_sel,
  output var  logic [N-1:0] o_edge
);

  logic [N-1:0] pin_d_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_d_ff <= '0;
      o_edge   <= '0;
    end else if (i_ce) begin
      pin_d_ff <= i_pin;
      // A one selects the rising edge and a zero the falling edge.
      o_edge   <= (i_rise_sel & i_pin & ~pin_d_ff) |
                  (~i_rise_sel & ~i_pin & pin_d_ff); // [RL14]
    end
  end

endmodule : tlip_edge_det
`default_nettype wire

// [core/tlip_top.sv]
// Two-level interrupt priority logic with AXI4-Lite register access.
// Assumes the core pulses return inputs at the end of each service routine.
// Behaviour
// [RL1] Rank pending requests by user level, then by fixed vector position.
// [RL2] Each source has a priority bit: one high, zero low.
// [RL3] Priority-levels enable set gives two levels, clear makes all high.
// [RL4] A high request beats an earlier pending low request.
// [RL5] Simultaneous high and low requests: high is serviced first.
// [RL6] High preempts a running low routine, which then resumes and completes.
// [RL7] High may preempt low; low never preempts high.
// [RL8] Same-level requests never nest; vector order or polling order decides.
// [RL9] Low enable cleared in high routine drops a waiting low request.
// [RL10] A preempted low routine resumes even if low enable was cleared.
// [RL11] Without levels, bit 7 enables all unmasked interrupts or blocks all.
// [RL12] With levels, bit 7 must be set for any interrupt to be taken.
// [RL13] Bit 6 is low enable only with levels, else reads as zero.
// [RL14] Bits 2..0 select rising or falling edge for external pins 2..0.
// [RL15] Reset clears enables and levels, sets edge selects; bits 4,3 read zero.
// [RL16] Priority register 7 holds five priority bits, all resetting high.
// [RL17] Priority register 8 holds timer 5 gate and timer 5 priority bits.
// [RL18] High and low vector requests are separate; low held while high runs.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tlip_top
  import tlip_pkg::*;
#(
  parameter int NSRC = NUM_SRC
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic [AXI_AW-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output var  logic              O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output var  logic              O_WREADY,
  output var  logic [1:0]        O_BRESP,
  output var  logic              O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [AXI_AW-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output var  logic              O_ARREADY,
  output var  logic [31:0]       O_RDATA,
  output var  logic [1:0]        O_RRESP,
  output var  logic              O_RVALID,
  input  wire logic              I_RREADY,
  input  wire logic [2:0]        I_EXT_IRQ_PIN,
  input  wire logic [NSRC-1:0]   I_PERIPH_REQ,
  input  wire logic              I_MULTI_VECTOR_ENABLE,
  input  wire logic              I_HIGH_RETURN,
  input  wire logic              I_LOW_RETURN,
  output var  logic              O_HIGH_VEC_REQ,
  output var  logic              O_LOW_VEC_REQ,
  output var  logic [2:0]        O_VEC_INDEX,
  output var  logic [2:0]        O_EXT_IRQ_EDGE
);

  // Source order in the vector table, index 0 first:
  // ext irq 2, logic cell 2, waveform gen 2, crc, timer 4, timer 5 gate, timer 5.

  logic [7:0]       ctrl_ff;
  logic [7:0]       prio7_ff;
  logic [7:0]       prio8_ff;
  tlip_svc_type     svc_ff;
  logic [NSRC-1:0]  src_prio;
  logic [NSRC-1:0]  req;
  logic [NSRC-1:0]  hi_req;
  logic [NSRC-1:0]  lo_req;
  logic [2:0]       ext_edge;
  logic             ple;
  logic             ghe;
  logic             gle;
  logic             take_high;
  logic             take_low;
  logic             aw_ok;
  logic             w_ok;
  logic [AXI_AW-1:0] aw_addr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             do_write;

  function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
    first_set = 3'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 3'(k);
      end
    end
  endfunction : first_set

  tlip_edge_det #(
    .N(3)
  ) u_edge (
    .i_clk      (I_CLK),
    .i_rst      (I_RST),
    .i_ce       (I_CE),
    .i_pin      (I_EXT_IRQ_PIN),
    .i_rise_sel (ctrl_ff[2:0]),
    .o_edge     (ext_edge)
  );

  assign ple = ctrl_ff[CTL_PLE_BIT];
  assign ghe = ctrl_ff[CTL_GHE_BIT];
  assign gle = ctrl_ff[CTL_GLE_BIT];

  assign src_prio = {prio8_ff[6], prio8_ff[7], prio7_ff[0], prio7_ff[1],
                     prio7_ff[3], prio7_ff[4], prio7_ff[5]}; // [RL2]

  assign req = {I_PERIPH_REQ[NSRC-1:1], I_PERIPH_REQ[0] | ext_edge[2]};

  // Without levels every source counts as high.
  assign hi_req = req & (ple ? src_prio : {NSRC{1'b1}}); // [RL3]
  assign lo_req = ple ? (req & ~src_prio) : '0; // [RL3]

  // High is taken from idle or a running low routine; low only from idle.
  assign take_high = ghe && (|hi_req) &&
                     (svc_ff == ST_IDLE || svc_ff == ST_LOW); // [RL4] [RL5] [RL7] [RL11] [RL12]
  assign take_low  = ghe && gle && ple && (|lo_req) && !(|hi_req) &&
                     svc_ff == ST_IDLE; // [RL8] [RL9] [RL12]

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      svc_ff <= ST_IDLE;
    end else if (I_CE) begin
      unique case (svc_ff)
        ST_IDLE: begin
          if (take_high) begin
            svc_ff <= ST_HIGH;
          end else if (take_low) begin
            svc_ff <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (take_high) begin
            svc_ff <= ST_LOW_PREEMPTED; // [RL6]
          end else if (I_LOW_RETURN) begin
            svc_ff <= ST_IDLE;
          end
        end
        ST_HIGH: begin
          if (I_HIGH_RETURN) begin
            svc_ff <= ST_IDLE;
          end
        end
        ST_LOW_PREEMPTED: begin
          // The low routine resumes regardless of the low enable.
          if (I_HIGH_RETURN) begin
            svc_ff <= ST_LOW; // [RL10]
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_HIGH_VEC_REQ <= 1'b0;
      O_LOW_VEC_REQ  <= 1'b0;
      O_VEC_INDEX    <= 3'h0;
    end else if (I_CE) begin
      O_HIGH_VEC_REQ <= take_high; // [RL18]
      O_LOW_VEC_REQ  <= take_low; // [RL18]
      if (take_high) begin
        O_VEC_INDEX <= I_MULTI_VECTOR_ENABLE ? first_set(hi_req) : 3'h0; // [RL1] [RL8]
      end else if (take_low) begin
        O_VEC_INDEX <= I_MULTI_VECTOR_ENABLE ? first_set(lo_req) : 3'h0; // [RL1] [RL8]
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_EXT_IRQ_EDGE <= 3'h0;
    end else if (I_CE) begin
      O_EXT_IRQ_EDGE <= ext_edge;
    end
  end

  // Write channel: address and data are latched in either order.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      aw_ok      <= 1'b0;
      w_ok       <= 1'b0;
      aw_addr_ff <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      O_AWREADY  <= 1'b1;
      O_WREADY   <= 1'b1;
      O_BVALID   <= 1'b0;
      O_BRESP    <= RESP_OKAY;
    end else if (I_CE) begin
      if (I_AWVALID && O_AWREADY) begin
        aw_ok      <= 1'b1;
        aw_addr_ff <= I_AWADDR;
        O_AWREADY  <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_ok      <= 1'b1;
        wdata_ff  <= I_WDATA;
        wstrb_ff  <= I_WSTRB;
        O_WREADY  <= 1'b0;
      end
      if (do_write) begin
        aw_ok    <= 1'b0;
        w_ok     <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_addr_ff[3:2] == OFS_STATE[3:2]) ? RESP_SLVERR : RESP_OKAY;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  assign do_write = aw_ok && w_ok && !O_BVALID;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_ff  <= CTL_RESET; // [RL15]
      prio7_ff <= PRIO7_RESET; // [RL16]
      prio8_ff <= PRIO8_RESET; // [RL17]
    end else if (I_CE && do_write && wstrb_ff[0]) begin
      unique case (aw_addr_ff[3:2])
        OFS_CTRL0[3:2]: ctrl_ff  <= wdata_ff[7:0] & CTL_WMASK; // [RL15]
        OFS_PRIO7[3:2]: prio7_ff <= wdata_ff[7:0] & PRIO7_WMASK; // [RL16]
        OFS_PRIO8[3:2]: prio8_ff <= wdata_ff[7:0] & PRIO8_WMASK; // [RL17]
        default: begin
        end
      endcase
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end else if (I_CE) begin
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RRESP   <= RESP_OKAY;
        unique case (I_ARADDR[3:2])
          OFS_CTRL0[3:2]: begin
            O_RDATA <= {24'h0, ctrl_ff[7], ctrl_ff[6] & ple, ctrl_ff[5:0]}; // [RL13]
          end
          OFS_PRIO7[3:2]: O_RDATA <= {24'h0, prio7_ff};
          OFS_PRIO8[3:2]: O_RDATA <= {24'h0, prio8_ff};
          OFS_STATE[3:2]: O_RDATA <= {30'h0, 2'(svc_ff)};
        endcase
      end
      if (O_RVALID && I_RREADY) begin
        O_RVALID  <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  no_low_nest_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL7]
    (svc_ff == ST_HIGH) |-> !O_LOW_VEC_REQ ##1 !O_LOW_VEC_REQ)
    else $error("Low request raised during a high routine.");

  resume_low_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL10]
    (I_CE && svc_ff == ST_LOW_PREEMPTED && I_HIGH_RETURN) |=> (svc_ff == ST_LOW))
    else $error("Preempted low routine did not resume.");

  preempt_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL6]
    (I_CE && svc_ff == ST_LOW && ghe && (|hi_req)) |=> O_HIGH_VEC_REQ)
    else $error("High request failed to preempt low routine.");

  high_first_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL5]
    (I_CE && svc_ff == ST_IDLE && ghe && (|hi_req) && (|lo_req)) |=>
      (O_HIGH_VEC_REQ && !O_LOW_VEC_REQ))
    else $error("Low serviced ahead of simultaneous high.");

  gie_block_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL12]
    (I_CE && !ghe) |=> (!O_HIGH_VEC_REQ && !O_LOW_VEC_REQ))
    else $error("Vector raised with high enable clear.");

  no_levels_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL3]
    (I_CE && !ple) |=> !O_LOW_VEC_REQ)
    else $error("Low vector raised with levels disabled.");

  low_drop_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL9]
    (I_CE && !gle) |=> !O_LOW_VEC_REQ)
    else $error("Low vector raised with low enable clear.");

  vec_order_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL1]
    (I_CE && take_high && I_MULTI_VECTOR_ENABLE && hi_req[0]) |=> (O_VEC_INDEX == 3'h0))
    else $error("Vector order not honoured.");

endmodule : tlip_top
`default_nettype wire

// [tb/tlip_core_model.sv]
// Core and request flag model: pending flags, flag clear on vector take, return pulses.
// Assumes the bench sets routine lengths and raises or clears flags with one-cycle masks.
`timescale 1ns/1ps
`default_nettype none
module tlip_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_high_vec,
  input  wire logic       i_low_vec,
  input  wire logic [2:0] i_vec_index,
  input  wire logic [7:0] i_high_len,
  input  wire logic [7:0] i_low_len,
  input  wire logic [6:0] i_set,
  input  wire logic [6:0] i_clr,
  output var  logic       o_high_ret,
  output var  logic       o_low_ret,
  output var  logic [6:0] o_pend
);
  logic [7:0] hcnt_ff;
  logic [7:0] lcnt_ff;
  logic [6:0] took;
  logic       hbusy;
  assign took  = (i_high_vec || i_low_vec) ? (7'h01 << i_vec_index) : 7'h00;
  assign hbusy = i_high_vec || (hcnt_ff != 8'h00);
  // The service routine clears its own flag; software may clear one at any time.
  always_ff @(posedge i_clk) begin
    if (i_rst) o_pend <= 7'h00;
    else o_pend <= (o_pend | i_set) & ~i_clr & ~took;
  end
  always_ff @(posedge i_clk) begin
    o_high_ret <= 1'b0;
    if (i_rst) hcnt_ff <= 8'h00;
    else if (i_high_vec) hcnt_ff <= i_high_len;
    else if (hcnt_ff != 8'h00) begin
      hcnt_ff    <= hcnt_ff - 8'h01;
      o_high_ret <= (hcnt_ff == 8'h01);
    end
  end
  // A low routine is frozen while a high one runs, then resumes.
  always_ff @(posedge i_clk) begin
    o_low_ret <= 1'b0;
    if (i_rst) lcnt_ff <= 8'h00;
    else if (i_low_vec) lcnt_ff <= i_low_len;
    else if (lcnt_ff != 8'h00 && !hbusy) begin
      lcnt_ff   <= lcnt_ff - 8'h01;
      o_low_ret <= (lcnt_ff == 8'h01);
    end
  end
endmodule : tlip_core_model
`default_nettype wire

// [tb/tb_tlip_top.sv]
// Testbench for tlip_top: bus master, request stimulus and a queued result monitor.
// Assumes tlip_core_model answers every vector with a return pulse.
`timescale 1ns/1ps
`default_nettype none
module tb_tlip_top
  import tlip_pkg::*;
;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [2:0]  pins;
  logic [6:0]  set_m, clr_m;
  logic [7:0]  hlen, llen, d;
  logic [7:0]  sels [3];
  wire logic awready, wready, bvalid, arready, rvalid, hvec, lvec, hret, lret;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  vidx, edg;
  wire logic [6:0]  req;
  logic [34:0] q[$];
  int mismatches, n_checks, r;

  tlip_top tlip_top_inst (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_EXT_IRQ_PIN(pins), .I_PERIPH_REQ(req), .I_MULTI_VECTOR_ENABLE(1'b1),
    .I_HIGH_RETURN(hret), .I_LOW_RETURN(lret), .O_HIGH_VEC_REQ(hvec),
    .O_LOW_VEC_REQ(lvec), .O_VEC_INDEX(vidx), .O_EXT_IRQ_EDGE(edg));
  tlip_core_model tlip_core_model_inst (.i_clk(clk), .i_rst(rst), .i_high_vec(hvec),
    .i_low_vec(lvec), .i_vec_index(vidx), .i_high_len(hlen), .i_low_len(llen),
    .i_set(set_m), .i_clr(clr_m), .o_high_ret(hret), .o_low_ret(lret), .o_pend(req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic take(input logic [34:0] seen);
    if (q.size() == 0) check(seen, 35'h7_FFFF_FFFF);
    else check(seen, q.pop_front());
  endtask : take

  // Results in order of appearance: kind 0 read, 1 high, 2 low, 3 write reply, 4 edge.
  always @(posedge clk) begin
    if (!rst && hvec) take({3'd1, 29'h0, vidx});
    if (!rst && lvec) take({3'd2, 29'h0, vidx});
    if (!rst && rvalid && rready) take({3'd0, rdata});
    if (!rst && bvalid && bready) take({3'd3, 30'h0, bresp});
    if (!rst && |edg) take({3'd4, 29'h0, edg});
  end

  task automatic fail_wait;
    mismatches++;
    stop_test();
  endtask : fail_wait

  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] rsp);
    int n;
    q.push_back({3'd3, 30'h0, rsp});
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {$urandom_range(255, 0), v, v, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (!bvalid) fail_wait();
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    int n;
    q.push_back({3'd0, 24'h0, v});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    if (!rvalid) fail_wait();
  endtask : rd

  task automatic raise(input logic [6:0] m);
    set_m <= m;
    @(posedge clk);
    set_m <= 7'h00;
  endtask : raise

  task automatic expect_vec(input logic [2:0] kind, input logic [2:0] idx);
    q.push_back({kind, 29'h0, idx});
  endtask : expect_vec

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, pins, set_m, clr_m} = '0;
    hlen = 8'h0A;
    llen = 8'h0A;
    rst = 1'b1;
    sels = '{8'h07, 8'h00, 8'h05};
    r = $urandom(32'h038D);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL0, 8'h07);
    rd(OFS_PRIO7, 8'h3B);
    rd(OFS_PRIO8, 8'hC0);
    wr(OFS_STATE, 8'hFF, RESP_SLVERR);
    rd(OFS_STATE, 8'h00);
    wr(OFS_CTRL0, 8'hFF, RESP_OKAY);
    rd(OFS_CTRL0, 8'hE7);
    wr(OFS_CTRL0, 8'h47, RESP_OKAY);
    rd(OFS_CTRL0, 8'h07);
    d = 8'($urandom);
    wr(OFS_PRIO7, d, RESP_OKAY);
    rd(OFS_PRIO7, d & 8'h3B);
    wr(OFS_PRIO8, ~d, RESP_OKAY);
    rd(OFS_PRIO8, ~d & 8'hC0);
    raise(7'h08);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL0, 8'h87, RESP_OKAY);
    expect_vec(3'd1, 3'd3);
    repeat (15) @(posedge clk);
    wr(OFS_PRIO7, 8'h20, RESP_OKAY);
    wr(OFS_PRIO8, 8'h40, RESP_OKAY);
    wr(OFS_CTRL0, 8'hE7, RESP_OKAY);
    expect_vec(3'd1, 3'd0);
    expect_vec(3'd2, 3'd1);
    raise(7'h03);
    repeat (30) @(posedge clk);
    wr(OFS_CTRL0, 8'h67, RESP_OKAY);
    raise(7'h02);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL0, 8'hE7, RESP_OKAY);
    expect_vec(3'd2, 3'd1);
    repeat (20) @(posedge clk);
    expect_vec(3'd2, 3'd1);
    expect_vec(3'd2, 3'd3);
    raise(7'h0A);
    repeat (40) @(posedge clk);
    wr(OFS_CTRL0, 8'hA7, RESP_OKAY);
    raise(7'h04);
    repeat (3) @(posedge clk);
    expect_vec(3'd1, 3'd6);
    raise(7'h40);
    repeat (20) @(posedge clk);
    wr(OFS_CTRL0, 8'hE7, RESP_OKAY);
    expect_vec(3'd2, 3'd2);
    repeat (20) @(posedge clk);
    hlen = 8'h14;
    llen = 8'h3C;
    expect_vec(3'd2, 3'd2);
    raise(7'h04);
    repeat (5) @(posedge clk);
    expect_vec(3'd1, 3'd6);
    raise(7'h40);
    repeat (4) @(posedge clk);
    wr(OFS_CTRL0, 8'hA7, RESP_OKAY);
    rd(OFS_STATE, 8'h03);
    repeat (25) @(posedge clk);
    rd(OFS_STATE, 8'h02);
    repeat (60) @(posedge clk);
    rd(OFS_STATE, 8'h00);
    hlen = 8'h1E;
    wr(OFS_CTRL0, 8'hE7, RESP_OKAY);
    expect_vec(3'd1, 3'd0);
    raise(7'h03);
    repeat (5) @(posedge clk);
    wr(OFS_CTRL0, 8'hA7, RESP_OKAY);
    repeat (40) @(posedge clk);
    clr_m <= 7'h02;
    @(posedge clk);
    clr_m <= 7'h00;
    wr(OFS_CTRL0, 8'hE7, RESP_OKAY);
    wr(OFS_PRIO7, 8'h10, RESP_OKAY);
    expect_vec(3'd1, 3'd1);
    expect_vec(3'd2, 3'd0);
    raise(7'h03);
    repeat (60) @(posedge clk);
    foreach (sels[i]) begin
      wr(OFS_CTRL0, sels[i], RESP_OKAY);
      if (sels[i][2:0] != 3'h0) expect_vec(3'd4, sels[i][2:0]);
      pins <= 3'h7;
      repeat (4) @(posedge clk);
      if (sels[i][2:0] != 3'h7) expect_vec(3'd4, ~sels[i][2:0]);
      pins <= 3'h0;
      repeat (4) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    if (q.size() != 0) mismatches++;
    stop_test();
  end
endmodule : tb_tlip_top
`default_nettype wire
